// ===== rtl/sssq_pkg.sv
// package of constants and types for the soft start mode sequencer
package sssq_pkg;
  // apb register byte offsets
  localparam logic [7:0] SSSQ_CFG_OFS = 8'h00;
  localparam logic [7:0] SSSQ_TIME_OFS = 8'h04;
  localparam logic [7:0] SSSQ_CUR_OFS = 8'h08;
  localparam logic [7:0] SSSQ_CTRL_OFS = 8'h0C;
  localparam logic [7:0] SSSQ_STAT_OFS = 8'h10;
  localparam logic [7:0] SSSQ_OUT_OFS = 8'h14;
  // cfg field positions
  localparam int SSSQ_CFG_METHOD_LSB = 0;
  localparam int SSSQ_CFG_VINIT_LSB = 8;
  localparam int SSSQ_CFG_DETECT_BIT = 16;
  localparam int SSSQ_CFG_STOP_LSB = 20;
  localparam int SSSQ_CFG_POINTS_LSB = 24;
  // cur field positions
  localparam int SSSQ_CUR_INIT_LSB = 0;
  localparam int SSSQ_CUR_FINAL_LSB = 10;
  localparam int SSSQ_CUR_FRAC_LSB = 20;
  // ranges and reset values
  localparam logic [2:0] SSSQ_METHOD_RST = 3'h1;
  localparam logic [6:0] SSSQ_VINIT_MIN = 7'h19;
  localparam logic [6:0] SSSQ_VINIT_MAX = 7'h5A;
  localparam logic [6:0] SSSQ_VINIT_RST = 7'h1E;
  localparam logic [6:0] SSSQ_VFULL = 7'h64;
  localparam logic [9:0] SSSQ_TIME_MIN = 10'h001;
  localparam logic [9:0] SSSQ_TIME_MAX = 10'h3E7;
  localparam logic [9:0] SSSQ_TIME_RST = 10'h014;
  localparam logic SSSQ_DETECT_RST = 1'b1;
  localparam logic [9:0] SSSQ_CUR_MIN = 10'h096;
  localparam logic [9:0] SSSQ_CUR_MAX = 10'h258;
  localparam logic [9:0] SSSQ_CINIT_RST = 10'h096;
  localparam logic [9:0] SSSQ_CFINAL_RST = 10'h12C;
  localparam logic [6:0] SSSQ_FRAC_MIN = 7'h01;
  localparam logic [6:0] SSSQ_FRAC_MAX = 7'h63;
  localparam logic [6:0] SSSQ_FRAC_RST = 7'h14;
  localparam logic [1:0] SSSQ_POINTS_RST = 2'h1;
  localparam logic [6:0] SSSQ_DETECT_PCT = 7'h5F;
  // timing: one second in clock cycles
  localparam longint SSSQ_CLK_HZ = 40000000;
  localparam int SSSQ_SEC_S = 1;
  localparam logic [25:0] SSSQ_SEC_CYC = 26'(SSSQ_CLK_HZ * SSSQ_SEC_S);

  typedef enum logic [2:0] {
    SSSQ_M_VRAMP = 3'b000, SSSQ_M_VRAMP_ILIM = 3'b001, SSSQ_M_ILIM = 3'b010,
    SSSQ_M_IRAMP = 3'b011, SSSQ_M_PUMP = 3'b100, SSSQ_M_TORQUE = 3'b101,
    SSSQ_M_DOL = 3'b110
  } sssq_method_e;

  typedef enum logic [1:0] {
    SSSQ_STOP_DIRECT = 2'b00, SSSQ_STOP_VRAMP = 2'b01,
    SSSQ_STOP_PUMP = 2'b10, SSSQ_STOP_TORQUE = 2'b11
  } sssq_stop_e;

  typedef enum logic [1:0] {
    SSSQ_S_STOPPED = 2'b00, SSSQ_S_STARTING = 2'b01,
    SSSQ_S_RUNNING = 2'b10, SSSQ_S_FAULT = 2'b11
  } sssq_state_e;
endpackage : sssq_pkg

// ===== rtl/sssq_tick_if.sv
// interface carrying the seconds tick and elapsed time
`timescale 1ns/10ps
interface sssq_tick_if;
  logic run;
  logic tick;
  logic [9:0] secs;
  modport timer (input run, output tick, output secs);
  modport user (output run, input tick, input secs);
endinterface : sssq_tick_if

// ===== rtl/sssq_timer.sv
// seconds timer for the start sequence
`timescale 1ns/10ps
module sssq_timer
  import sssq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick link
  sssq_tick_if.timer tk
);
  typedef struct packed {
    logic [25:0] pre;
    logic [9:0] secs;
    logic tick;
  } sssq_tmr_s;

  sssq_tmr_s q;
  sssq_tmr_s next_q;

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (!tk.run) begin
      next_q.pre = '0;
      next_q.secs = '0;
    end else if (q.pre == SSSQ_SEC_CYC - 26'd1) begin
      next_q.pre = '0;
      next_q.tick = 1'b1;
      // saturate so a long fault wait never wraps
      if (q.secs != 10'h3FF) begin
        next_q.secs = q.secs + 10'd1;
      end
    end else begin
      next_q.pre = q.pre + 26'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tk.tick = q.tick;
  assign tk.secs = q.secs;
endmodule : sssq_timer

// ===== rtl/sssq_sequencer.sv
// soft start mode sequencer with apb settings registers
`timescale 1ns/10ps
module sssq_sequencer
  import sssq_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements, percent of nominal (line/motor) and rated current
  input wire logic [6:0] measured_motor_voltage,
  input wire logic [6:0] measured_line_voltage,
  input wire logic [9:0] measured_current,
  input wire logic [9:0] measured_torque,
  // thyristor stage commands
  output logic [6:0] voltage_ref,
  output logic [9:0] current_limit_ref,
  output logic current_reg_en,
  output logic [9:0] torque_limit_ref,
  output logic torque_reg_en,
  output logic full_voltage,
  output logic locked_rotor_fault,
  output logic [1:0] stop_method
);
  typedef struct packed {
    logic [2:0] method;
    logic [6:0] vinit;
    logic [9:0] tmax;
    logic detect;
    logic [9:0] cinit;
    logic [9:0] cfinal;
    logic [6:0] frac;
    logic [1:0] points;
    logic [1:0] stop_sel;
    sssq_state_e st;
    logic limit_hit;
    logic [31:0] vacc;
    logic [6:0] vref;
    logic [9:0] iref;
    logic ireg;
    logic [9:0] tref;
    logic treg;
    logic full;
    logic fault;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } sssq_state_s;

  sssq_state_s q;
  sssq_state_s next_q;
  sssq_tick_if tk();
  // the three-stage synchronisers for the measured voltages and current
  logic [6:0] vm_s1, vm_s2, vm_s3, vl_s1, vl_s2, vl_s3;
  logic [9:0] im_s1, im_s2, im_s3;
  logic [6:0] vm, vl;
  logic [9:0] im;

  sssq_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk.timer)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {vm_s1, vm_s2, vm_s3, vl_s1, vl_s2, vl_s3} <= '0;
      {im_s1, im_s2, im_s3, vm, vl, im} <= '0;
    end else begin
      {vm_s1, vm_s2, vm_s3} <= {measured_motor_voltage, vm_s1, vm_s2};
      {vl_s1, vl_s2, vl_s3} <= {measured_line_voltage, vl_s1, vl_s2};
      {im_s1, im_s2, im_s3} <= {measured_current, im_s1, im_s2};
      if (vm_s2 == vm_s3) vm <= vm_s3;
      if (vl_s2 == vl_s3) vl <= vl_s3;
      if (im_s2 == im_s3) im <= im_s3;
    end
  end

  logic stopped, wr, rd, ramp_mth, lim_mth;
  logic [9:0] ilim_tgt;
  logic [16:0] frac_secs;
  logic [31:0] vstep;
  logic [13:0] vm100, vl95;
  logic [9:0] tq_lo, tq_hi, tq_mid;

  // torque points are fixed percentages; their tuning is outside this block
  localparam logic [9:0] SSSQ_TQ_INIT = 10'h01E;
  localparam logic [9:0] SSSQ_TQ_END = 10'h06E;
  localparam logic [9:0] SSSQ_TQ_MIN = 10'h01B;

  function automatic logic stop_ok(input logic [2:0] m, input logic [1:0] s);
    case (s)
      SSSQ_STOP_DIRECT: stop_ok = 1'b1;
      SSSQ_STOP_VRAMP: stop_ok = (m <= SSSQ_M_IRAMP);
      SSSQ_STOP_PUMP: stop_ok = (m == SSSQ_M_PUMP);
      SSSQ_STOP_TORQUE: stop_ok = (m == SSSQ_M_TORQUE);
      default: stop_ok = 1'b0;
    endcase
  endfunction : stop_ok

  assign tk.run = (q.st == SSSQ_S_STARTING);

  always_comb begin
    next_q = q;
    stopped = (q.st == SSSQ_S_STOPPED) || (q.st == SSSQ_S_FAULT);
    wr = psel && penable && pwrite && q.ready;
    rd = psel && !penable;
    ramp_mth = (q.method == SSSQ_M_VRAMP) || (q.method == SSSQ_M_PUMP);
    lim_mth = (q.method == SSSQ_M_VRAMP_ILIM) || (q.method == SSSQ_M_ILIM) ||
              (q.method == SSSQ_M_IRAMP) || (q.method == SSSQ_M_TORQUE);
    frac_secs = 17'((q.tmax * q.frac) / 7'd100);
    // ramp increment per second in 24-bit fraction of one percent
    vstep = 32'((32'(SSSQ_VFULL - q.vinit) << 24) / 32'(q.tmax));
    vm100 = 14'(vm) * 14'd100;
    vl95 = 14'(vl) * 14'(SSSQ_DETECT_PCT);
    ilim_tgt = q.cfinal;
    if (q.method == SSSQ_M_IRAMP && 17'(tk.secs) < frac_secs) begin
      ilim_tgt = q.cinit;
    end
    tq_lo = SSSQ_TQ_INIT;
    tq_hi = SSSQ_TQ_END;
    tq_mid = SSSQ_TQ_MIN;
    // apb answers one cycle into access; a write lands on the edge that samples pready
    next_q.ready = psel && penable && !q.ready;
    next_q.err = 1'b0;
    if (rd) begin
      case (paddr)
        SSSQ_CFG_OFS: next_q.rdata = {6'h0, q.points, 2'h0, q.stop_sel, 3'h0,
                                      q.detect, 1'b0, q.vinit, 5'h0, q.method};
        SSSQ_TIME_OFS: next_q.rdata = {22'h0, q.tmax};
        SSSQ_CUR_OFS: next_q.rdata = {5'h0, q.frac, q.cfinal, q.cinit};
        SSSQ_CTRL_OFS: next_q.rdata = '0;
        SSSQ_STAT_OFS: next_q.rdata = {14'h0, tk.secs, 4'h0, q.limit_hit,
                                       q.fault, 2'(q.st)};
        SSSQ_OUT_OFS: next_q.rdata = {5'h0, q.tref, q.iref, q.vref};
        default: next_q.rdata = '0;
      endcase
    end
    if (psel && penable && !q.ready) begin
      next_q.err = !(paddr inside {SSSQ_CFG_OFS, SSSQ_TIME_OFS, SSSQ_CUR_OFS,
                                   SSSQ_CTRL_OFS, SSSQ_STAT_OFS, SSSQ_OUT_OFS});
    end
    // settings take effect only while stopped or in fault; out of range values ignored
    if (wr && stopped) begin
      case (paddr)
        SSSQ_CFG_OFS: begin
          if (pwdata[SSSQ_CFG_METHOD_LSB +: 3] <= SSSQ_M_DOL) begin
            next_q.method = pwdata[SSSQ_CFG_METHOD_LSB +: 3];
          end
          if (pwdata[SSSQ_CFG_VINIT_LSB +: 7] >= SSSQ_VINIT_MIN &&
              pwdata[SSSQ_CFG_VINIT_LSB +: 7] <= SSSQ_VINIT_MAX) begin
            next_q.vinit = pwdata[SSSQ_CFG_VINIT_LSB +: 7];
          end
          next_q.detect = pwdata[SSSQ_CFG_DETECT_BIT];
          next_q.stop_sel = pwdata[SSSQ_CFG_STOP_LSB +: 2];
          if (pwdata[SSSQ_CFG_POINTS_LSB +: 2] != 2'd0) begin
            next_q.points = pwdata[SSSQ_CFG_POINTS_LSB +: 2];
          end
        end
        SSSQ_TIME_OFS: begin
          if (pwdata[9:0] >= SSSQ_TIME_MIN && pwdata[9:0] <= SSSQ_TIME_MAX) begin
            next_q.tmax = pwdata[9:0];
          end
        end
        SSSQ_CUR_OFS: begin
          if (pwdata[SSSQ_CUR_INIT_LSB +: 10] inside {[SSSQ_CUR_MIN:SSSQ_CUR_MAX]}) begin
            next_q.cinit = pwdata[SSSQ_CUR_INIT_LSB +: 10];
          end
          if (pwdata[SSSQ_CUR_FINAL_LSB +: 10] inside {[SSSQ_CUR_MIN:SSSQ_CUR_MAX]}) begin
            next_q.cfinal = pwdata[SSSQ_CUR_FINAL_LSB +: 10];
          end
          if (pwdata[SSSQ_CUR_FRAC_LSB +: 7] inside {[SSSQ_FRAC_MIN:SSSQ_FRAC_MAX]}) begin
            next_q.frac = pwdata[SSSQ_CUR_FRAC_LSB +: 7];
          end
        end
        default: begin
        end
      endcase
    end
    // a stop selection that the method does not allow falls back to direct
    if (!stop_ok(next_q.method, next_q.stop_sel)) begin
      next_q.stop_sel = SSSQ_STOP_DIRECT;
    end
    case (q.st)
      SSSQ_S_STOPPED, SSSQ_S_FAULT: begin
        next_q.full = 1'b0;
        next_q.ireg = 1'b0;
        next_q.treg = 1'b0;
        next_q.vref = '0;
        if (wr && paddr == SSSQ_CTRL_OFS && pwdata[0]) begin
          next_q.st = SSSQ_S_STARTING;
          next_q.fault = 1'b0;
          next_q.limit_hit = 1'b0;
          next_q.vacc = {1'b0, q.vinit, 24'h0};
          next_q.vref = q.vinit;
          if (q.method == SSSQ_M_DOL) begin
            next_q.vref = SSSQ_VFULL;
            next_q.full = 1'b1;
            next_q.st = SSSQ_S_RUNNING;
          end
        end
      end
      SSSQ_S_STARTING: begin
        if (ramp_mth && tk.tick) begin
          next_q.vacc = q.vacc + vstep;
        end
        next_q.vref = (q.vacc[30:24] > SSSQ_VFULL) ? SSSQ_VFULL : q.vacc[30:24];
        next_q.iref = ilim_tgt;
        next_q.ireg = 1'b0;
        next_q.treg = 1'b0;
        case (q.method)
          SSSQ_M_VRAMP_ILIM: begin
            if (im >= q.cfinal) next_q.limit_hit = 1'b1;
            next_q.ireg = q.limit_hit || im >= q.cfinal;
          end
          SSSQ_M_ILIM, SSSQ_M_IRAMP: begin
            next_q.ireg = 1'b1;
            if (im >= ilim_tgt) next_q.limit_hit = 1'b1;
          end
          SSSQ_M_TORQUE: begin
            next_q.treg = 1'b1;
            case (q.points)
              2'd2: next_q.tref = 10'(tq_lo + 10'(
                                  (20'(tq_hi - tq_lo) * 20'(tk.secs)) / 20'(q.tmax)));
              2'd3: next_q.tref = (17'(tk.secs) < frac_secs) ? tq_lo :
                                  (17'(tk.secs) < 17'(q.tmax) - 17'd1) ? tq_mid : tq_hi;
              default: next_q.tref = tq_lo;
            endcase
          end
          default: begin
          end
        endcase
        // current-regulated methods may pull the initial voltage down to stay in limit
        if (next_q.ireg && im > ilim_tgt && q.vref > 7'd0) begin
          next_q.vref = q.vref - 7'd1;
          next_q.vacc = {1'b0, q.vref - 7'd1, 24'h0};
        end
        if (q.method == SSSQ_M_VRAMP && q.detect && vm100 >= vl95 && vl != 7'd0) begin
          next_q.full = 1'b1;
          next_q.vref = SSSQ_VFULL;
          next_q.st = SSSQ_S_RUNNING;
        end else if (tk.secs >= q.tmax) begin
          if (lim_mth) begin
            next_q.fault = 1'b1;
            next_q.st = SSSQ_S_FAULT;
          end else begin
            next_q.full = 1'b1;
            next_q.vref = SSSQ_VFULL;
            next_q.st = SSSQ_S_RUNNING;
          end
        end else if (lim_mth && q.detect && vm100 >= vl95 && vl != 7'd0) begin
          next_q.full = 1'b1;
          next_q.vref = SSSQ_VFULL;
          next_q.st = SSSQ_S_RUNNING;
        end
      end
      SSSQ_S_RUNNING: begin
        next_q.ireg = 1'b0;
        next_q.treg = 1'b0;
        next_q.vref = SSSQ_VFULL;
        next_q.full = 1'b1;
      end
      default: next_q.st = SSSQ_S_STOPPED;
    endcase
    if (wr && paddr == SSSQ_CTRL_OFS && pwdata[1]) begin
      next_q.st = SSSQ_S_STOPPED;
      next_q.full = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.method <= SSSQ_METHOD_RST;
      q.vinit <= SSSQ_VINIT_RST;
      q.tmax <= SSSQ_TIME_RST;
      q.detect <= SSSQ_DETECT_RST;
      q.cinit <= SSSQ_CINIT_RST;
      q.cfinal <= SSSQ_CFINAL_RST;
      q.frac <= SSSQ_FRAC_RST;
      q.points <= SSSQ_POINTS_RST;
      q.st <= SSSQ_S_STOPPED;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign voltage_ref = q.vref;
  assign current_limit_ref = q.iref;
  assign current_reg_en = q.ireg;
  assign torque_limit_ref = q.tref;
  assign torque_reg_en = q.treg;
  assign full_voltage = q.full;
  assign locked_rotor_fault = q.fault;
  assign stop_method = q.stop_sel;
endmodule : sssq_sequencer

// ===== bench/sssq_motor_model.sv
// behavioural motor and thyristor stage seen through the measurement inputs
`timescale 1ns/10ps
module sssq_motor_model
  import sssq_pkg::*;
(
  // stage command
  input wire logic [6:0] voltage_ref,
  // bench control: motor already at rated speed
  input wire logic at_speed,
  // measurements
  output logic [6:0] measured_motor_voltage,
  output logic [6:0] measured_line_voltage,
  output logic [9:0] measured_current,
  output logic [9:0] measured_torque
);
  // stiff supply, so the line reads nominal whatever the motor draws
  assign measured_line_voltage = SSSQ_VFULL;
  // at rated speed the back voltage sits just above the end threshold
  assign measured_motor_voltage = at_speed ? 7'h60 : voltage_ref;
  // current rises ten percent of rated per percent of applied voltage
  assign measured_current = 10'(voltage_ref) * 10'h00A;
  assign measured_torque = measured_current >> 2;
endmodule : sssq_motor_model

// ===== bench/sssq_seq_chk.sv
// port checker for the soft start mode sequencer
`timescale 1ns/10ps
module sssq_seq_chk
  import sssq_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // stage commands
  input wire logic [6:0] voltage_ref,
  input wire logic [9:0] current_limit_ref,
  input wire logic current_reg_en,
  input wire logic torque_reg_en,
  input wire logic full_voltage,
  input wire logic [1:0] stop_method
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  property p_full_level;
    full_voltage |-> voltage_ref == SSSQ_VFULL;
  endproperty
  property p_vref_cap;
    voltage_ref <= SSSQ_VFULL;
  endproperty
  property p_ilim_range;
    current_reg_en |-> current_limit_ref >= SSSQ_CUR_MIN && current_limit_ref <= SSSQ_CUR_MAX;
  endproperty
  property p_torque_stop;
    torque_reg_en |-> stop_method inside {SSSQ_STOP_DIRECT, SSSQ_STOP_TORQUE};
  endproperty
  property p_current_stop;
    current_reg_en |-> stop_method inside {SSSQ_STOP_DIRECT, SSSQ_STOP_VRAMP};
  endproperty
  property p_one_reg;
    torque_reg_en |-> !current_reg_en;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late or long");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_full_level: assert property (p_full_level) else $error("full flag below full");
  a_vref_cap: assert property (p_vref_cap) else $error("voltage above nominal");
  a_ilim_range: assert property (p_ilim_range) else $error("limit out of range");
  a_torque_stop: assert property (p_torque_stop) else $error("bad torque stop");
  a_current_stop: assert property (p_current_stop) else $error("bad limit stop");
  a_one_reg: assert property (p_one_reg) else $error("two regulators on");
endmodule : sssq_seq_chk

bind sssq_sequencer sssq_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .voltage_ref(voltage_ref),
  .current_limit_ref(current_limit_ref), .current_reg_en(current_reg_en),
  .torque_reg_en(torque_reg_en), .full_voltage(full_voltage), .stop_method(stop_method));

// ===== bench/sssq_sequencer_tb_top.sv
// self-checking bench for the soft start mode sequencer
`timescale 1ns/10ps
module sssq_sequencer_tb_top
  import sssq_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] m; logic [31:0] e;} sssq_row_s;
  typedef struct {logic [31:0] cfg; logic [31:0] cur; logic [31:0] m; logic [31:0] e;} sssq_run_s;
  localparam logic [31:0] MC = 32'h0331_7F07;
  localparam logic [31:0] MT = 32'h0000_03FF;
  localparam logic [31:0] MU = 32'h07FF_FFFF;
  localparam logic [31:0] MV = 32'hFE00_400F;
  localparam logic [31:0] MI = 32'h01FF_C00F;
  localparam logic [31:0] MQ = 32'h0000_7FFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic at_speed = 1'b0;
  logic [31:0] prdata, q, obs;
  logic pready, pslverr, e, current_reg_en, torque_reg_en, full_voltage, locked_rotor_fault;
  logic [6:0] voltage_ref, mmv, mlv;
  logic [9:0] current_limit_ref, torque_limit_ref, mcur, mtq;
  logic [1:0] stop_method;
  int n_fail = 0;
  int checks = 0;
  int i;
  sssq_row_s rows [0:18] = '{
    '{SSSQ_CFG_OFS, 32'h0211_2800, MC, 32'h0211_2800}, '{SSSQ_CFG_OFS, 32'h0211_1800, MC, 32'h0211_2800},
    '{SSSQ_CFG_OFS, 32'h0211_1900, MC, 32'h0211_1900}, '{SSSQ_CFG_OFS, 32'h0211_5B00, MC, 32'h0211_1900},
    '{SSSQ_CFG_OFS, 32'h0211_5A00, MC, 32'h0211_5A00}, '{SSSQ_CFG_OFS, 32'h0121_2804, MC, 32'h0121_2804},
    '{SSSQ_CFG_OFS, 32'h0111_2804, MC, 32'h0101_2804}, '{SSSQ_CFG_OFS, 32'h0131_2805, MC, 32'h0131_2805},
    '{SSSQ_CFG_OFS, 32'h0111_2806, MC, 32'h0101_2806}, '{SSSQ_CFG_OFS, 32'h0121_2802, MC, 32'h0101_2802},
    '{SSSQ_CFG_OFS, 32'h0111_2803, MC, 32'h0111_2803}, '{SSSQ_CFG_OFS, 32'h0111_2807, MC, 32'h0111_2803},
    '{SSSQ_TIME_OFS, 32'h0000_0000, MT, 32'h0000_0014}, '{SSSQ_TIME_OFS, 32'h0000_0001, MT, 32'h0000_0001},
    '{SSSQ_TIME_OFS, 32'h0000_03E7, MT, 32'h0000_03E7}, '{SSSQ_TIME_OFS, 32'h0000_03E8, MT, 32'h0000_03E7},
    '{SSSQ_CUR_OFS, 32'h0323_2190, MU, 32'h0323_2190}, '{SSSQ_CUR_OFS, 32'h0009_6495, MU, 32'h0323_2190},
    '{SSSQ_CUR_OFS, 32'h0639_6096, MU, 32'h0639_6096}};
  sssq_run_s runs [0:7] = '{
    '{32'h0110_2800, 32'h0143_2096, MV, 32'h5000_0001}, '{32'h0120_2804, 32'h0143_2096, MV, 32'h5000_0002},
    '{32'h0110_2802, 32'h0143_2096, MI, 32'h0064_4001}, '{32'h0110_2803, 32'h0143_2190, MI, 32'h00C8_4001},
    '{32'h0130_2805, 32'h0143_2096, MQ, 32'h0000_01EB}, '{32'h0230_2805, 32'h0143_2096, MQ, 32'h0000_01EB},
    '{32'h0330_2805, 32'h0143_2096, MQ, 32'h0000_01EB},
    '{32'h0100_2806, 32'h0143_2096, MV, 32'hC800_0004}};

  assign obs = {voltage_ref, current_limit_ref, current_reg_en, torque_limit_ref, torque_reg_en,
    full_voltage, stop_method};

  always #12.5 pclk = ~pclk;

  sssq_motor_model u_motor (.voltage_ref(voltage_ref), .at_speed(at_speed),
    .measured_motor_voltage(mmv), .measured_line_voltage(mlv), .measured_current(mcur),
    .measured_torque(mtq));

  sssq_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measured_motor_voltage(mmv), .measured_line_voltage(mlv),
    .measured_current(mcur), .measured_torque(mtq), .voltage_ref(voltage_ref),
    .current_limit_ref(current_limit_ref), .current_reg_en(current_reg_en),
    .torque_limit_ref(torque_limit_ref), .torque_reg_en(torque_reg_en),
    .full_voltage(full_voltage), .locked_rotor_fault(locked_rotor_fault),
    .stop_method(stop_method));

  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen at a rising edge; data taken at that edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(SSSQ_CFG_OFS, 1'b0, 32'h0);
    chk(q & 32'h0301_7F07, 32'h0101_1E01);
    apb(SSSQ_TIME_OFS, 1'b0, 32'h0);
    chk(q & MT, 32'h0000_0014);
    apb(SSSQ_CUR_OFS, 1'b0, 32'h0);
    chk(q & MU, 32'h0144_B096);
    apb(8'h18, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h0000_0001);
    $display("reset values done");
    foreach (rows[k]) begin
      apb(rows[k].a, 1'b1, rows[k].w);
      apb(rows[k].a, 1'b0, 32'h0);
      chk(q & rows[k].m, rows[k].e);
    end
    $display("setting rows done");
    apb(SSSQ_TIME_OFS, 1'b1, 32'h0000_0014);
    foreach (runs[k]) begin
      apb(SSSQ_CFG_OFS, 1'b1, runs[k].cfg);
      apb(SSSQ_CUR_OFS, 1'b1, runs[k].cur);
      apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      chk(obs & runs[k].m, runs[k].e);
      apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0002);
      apb(SSSQ_STAT_OFS, 1'b0, 32'h0);
      chk(q & 32'h0000_0007, 32'h0000_0000);
      $display("start case %0d done", k);
    end
    // time-only end must ignore a motor already at speed
    apb(SSSQ_CFG_OFS, 1'b1, 32'h0100_2800);
    apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0001);
    at_speed <= 1'b1;
    repeat (40) @(posedge pclk);
    chk({31'h0, full_voltage}, 32'h0000_0000);
    apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0002);
    at_speed <= 1'b0;
    apb(SSSQ_CFG_OFS, 1'b1, 32'h0101_2800);
    apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    at_speed <= 1'b1;
    for (i = 0; i < 40 && full_voltage !== 1'b1; i++) @(posedge pclk);
    if (full_voltage !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    chk(obs & 32'hFE00_0004, 32'hC800_0004);
    apb(SSSQ_STAT_OFS, 1'b0, 32'h0);
    chk(q & 32'h0000_0003, 32'h0000_0002);
    apb(SSSQ_CFG_OFS, 1'b1, 32'h0101_2802);
    apb(SSSQ_TIME_OFS, 1'b1, 32'h0000_0001);
    apb(SSSQ_CFG_OFS, 1'b0, 32'h0);
    chk(q & MC, 32'h0101_2800);
    apb(SSSQ_TIME_OFS, 1'b0, 32'h0);
    chk(q & MT, 32'h0000_0014);
    apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0002);
    at_speed <= 1'b0;
    $display("end detection done");
    // ramp with limit: model current passes the limit at this initial voltage
    apb(SSSQ_CFG_OFS, 1'b1, 32'h0100_2801);
    apb(SSSQ_CUR_OFS, 1'b1, 32'h0144_B096);
    apb(SSSQ_CTRL_OFS, 1'b1, 32'h0000_0001);
    q = 32'h0;
    for (i = 0; i < 20 && q[3] !== 1'b1; i++) apb(SSSQ_STAT_OFS, 1'b0, 32'h0);
    if (q[3] !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    chk(q & 32'h0000_0008, 32'h0000_0008);
    chk(obs & 32'h01FF_C000, 32'h0096_4000);
    chk({31'h0, locked_rotor_fault}, 32'h0000_0000);
    $display("ramp with limit done");
    // reset in mid start clears outputs and restores reset settings
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(obs, 32'h0000_0000);
    presetn <= 1'b1;
    apb(SSSQ_CFG_OFS, 1'b0, 32'h0);
    chk(q & 32'h0301_7F07, 32'h0101_1E01);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : sssq_sequencer_tb_top
